// File: rtl/qcr_top.v
/*
 * Quadrature counter register block: velocity counter, position and index
 * counters with holding registers, initialization/capture value,
 * status flags and one interrupt, all behind an AHB-Lite slave.
 * Assumes the phase, index and home inputs are already conditioned and
 * synchronous to i_clk, and a single AHB-Lite master with word access.
 */
`timescale 1ns/1ps
`include "qcr_defs.vh"

module qcr_top #(
  parameter ADDR_W = 8
) (
  input wire i_clk,
  input wire i_arst_n,
  input wire i_hsel,
  input wire [ADDR_W-1:0] i_haddr,
  input wire [1:0] i_htrans,
  input wire i_hwrite,
  input wire [2:0] i_hsize,
  input wire [31:0] i_hwdata,
  input wire i_hready,
  output reg [31:0] o_hrdata,
  output reg o_hreadyout,
  output reg o_hresp,
  input wire i_qea,
  input wire i_qeb,
  input wire i_index,
  input wire i_home,
  output reg o_irq
);

  // --------------------------------------------------------------------
  // Bus state machine
  // --------------------------------------------------------------------
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_DATA = 2'b10;

  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [5:0] addr_q;
  reg wr_q;
  reg map_q;
  wire take;
  wire act;
  wire do_wr;
  wire do_rd;

  assign take = i_hsel & i_htrans[1] & i_hready;
  assign act = state_q == ST_DATA;
  assign do_wr = act & wr_q & map_q;
  assign do_rd = act & ~wr_q & map_q;

  always @* begin
    case (state_q)
      ST_IDLE: state_d = take ? ST_DATA : ST_IDLE;
      ST_DATA: state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_q <= ST_IDLE;
      addr_q <= 6'h00;
      wr_q <= 1'b0;
      map_q <= 1'b0;
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
    end else begin
      state_q <= state_d;
      o_hreadyout <= ~(state_q == ST_IDLE && take);
      o_hresp <= 1'b0;
      if (state_q == ST_IDLE && take) begin
        addr_q <= {i_haddr[5:2], 2'b00};
        wr_q <= i_hwrite;
        map_q <= (i_haddr[ADDR_W-1:6] == {(ADDR_W-6){1'b0}});
      end
    end
  end

  // --------------------------------------------------------------------
  // Write strobes per register, read strobes r_pl and r_il
  // --------------------------------------------------------------------
  wire w_st = do_wr & (addr_q == `QCR_OFS_STATUS);
  wire w_ph = do_wr & (addr_q == `QCR_OFS_POS_HI);
  wire w_pl = do_wr & (addr_q == `QCR_OFS_POS_LO);
  wire w_phd = do_wr & (addr_q == `QCR_OFS_POS_HOLD);
  wire w_vel = do_wr & (addr_q == `QCR_OFS_VEL);
  wire w_ih = do_wr & (addr_q == `QCR_OFS_IDX_HI);
  wire w_il = do_wr & (addr_q == `QCR_OFS_IDX_LO);
  wire w_ihd = do_wr & (addr_q == `QCR_OFS_IDX_HOLD);
  wire w_ch = do_wr & (addr_q == `QCR_OFS_IC_HI);
  wire w_cl = do_wr & (addr_q == `QCR_OFS_IC_LO);
  wire w_ct = do_wr & (addr_q == `QCR_OFS_CTRL);
  wire w_mk = do_wr & (addr_q == `QCR_OFS_MASK);
  wire r_pl = do_rd & (addr_q == `QCR_OFS_POS_LO);
  wire r_il = do_rd & (addr_q == `QCR_OFS_IDX_LO);
  wire [15:0] wd = i_hwdata[15:0];

  // --------------------------------------------------------------------
  // Control register
  // --------------------------------------------------------------------
  reg [6:0] ctrl_q;
  wire [1:0] counter_control_mode;
  wire [2:0] position_init_mode;
  wire [1:0] index_match_value;

  assign counter_control_mode = ctrl_q[`QCR_CT_CCM_LSB+1:`QCR_CT_CCM_LSB];
  assign position_init_mode = ctrl_q[`QCR_CT_PIM_LSB+2:`QCR_CT_PIM_LSB];
  assign index_match_value = ctrl_q[`QCR_CT_IMV_LSB+1:`QCR_CT_IMV_LSB];

  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ctrl_q <= `QCR_RST_CTRL;
    end else if (w_ct) begin
      ctrl_q <= i_hwdata[6:0];
    end
  end

  // --------------------------------------------------------------------
  // Input edge and step detection
  // --------------------------------------------------------------------
  reg a_q;
  reg b_q;
  reg idx_q;
  reg home_q;
  reg armed_q;
  wire idx_ev;
  wire home_ev;
  wire quad;
  wire step;
  wire up;
  wire match;
  wire homing_mode;
  wire home_init;

  assign idx_ev = i_index & ~idx_q;
  assign home_ev = i_home & ~home_q;
  assign quad = counter_control_mode == `QCR_CCM_QUAD;
  assign step = quad ? ((i_qea ^ a_q) | (i_qeb ^ b_q)) :
    (counter_control_mode == `QCR_CCM_EXT_DIR) ? (i_qea & ~a_q) : 1'b1;
  assign up = quad ? (i_qea ^ b_q) :
    (counter_control_mode == `QCR_CCM_EXT_DIR) ? i_qeb : 1'b1;
  assign match = quad & idx_ev &
    ({i_qeb, i_qea} == index_match_value);
  assign homing_mode = counter_control_mode[1] == 1'b0 &&
    (position_init_mode == `QCR_PIM_HOME_A ||
     position_init_mode == `QCR_PIM_HOME_B);
  assign home_init = homing_mode & armed_q & idx_ev;

  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      a_q <= 1'b0;
      b_q <= 1'b0;
      idx_q <= 1'b0;
      home_q <= 1'b0;
      armed_q <= 1'b0;
    end else begin
      a_q <= i_qea;
      b_q <= i_qeb;
      idx_q <= i_index;
      home_q <= i_home;
      if (!homing_mode || home_init) begin
        armed_q <= 1'b0;
      end else if (home_ev) begin
        armed_q <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------
  // Position count and hold
  // --------------------------------------------------------------------
  reg [31:0] pos_q;
  reg [31:0] pos_d;
  reg [15:0] pos_hold_q;
  reg [31:0] ic_q;

  always @* begin
    pos_d = pos_q;
    if (home_init) begin
      pos_d = ic_q;
    end else if (match) begin
      pos_d = 32'h0000_0000;
    end else if (step) begin
      pos_d = up ? pos_q + 32'h0000_0001 : pos_q - 32'h0000_0001;
    end
    if (w_ph) begin
      pos_d[31:16] = wd;
    end
    if (w_pl) begin
      pos_d = {pos_hold_q, wd};
    end
  end

  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pos_q <= {`QCR_RST_W16, `QCR_RST_W16};
      pos_hold_q <= `QCR_RST_W16;
    end else begin
      pos_q <= pos_d;
      if (w_phd) begin
        pos_hold_q <= wd;
      end else if (r_pl) begin
        pos_hold_q <= pos_q[31:16];
      end
    end
  end

  // --------------------------------------------------------------------
  // Count direction, kept between steps
  // --------------------------------------------------------------------
  reg dir_q;
  wire dir;

  // A still encoder keeps the direction of its last step
  assign dir = step ? up : dir_q;

  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      dir_q <= 1'b1;
    end else begin
      dir_q <= dir;
    end
  end

  // --------------------------------------------------------------------
  // Velocity count
  // --------------------------------------------------------------------
  reg [15:0] vel_q;

  // Counts the same steps as the position count, and also those lost there to an index match or homing load
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      vel_q <= `QCR_RST_W16;
    end else if (w_vel) begin
      vel_q <= wd;
    end else if (step) begin
      vel_q <= up ? vel_q + 16'h0001 : vel_q - 16'h0001;
    end
  end

  // --------------------------------------------------------------------
  // Index count and hold
  // --------------------------------------------------------------------
  reg [31:0] idx_cnt_q;
  reg [15:0] idx_hold_q;

  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      idx_cnt_q <= {`QCR_RST_W16, `QCR_RST_W16};
      idx_hold_q <= `QCR_RST_W16;
    end else begin
      if (w_il) begin
        idx_cnt_q <= {idx_hold_q, wd};
      end else if (w_ih) begin
        idx_cnt_q[31:16] <= wd;
      end else if (idx_ev) begin
        idx_cnt_q <= dir ? idx_cnt_q + 32'h0000_0001 :
          idx_cnt_q - 32'h0000_0001;
      end
      if (w_ihd) begin
        idx_hold_q <= wd;
      end else if (r_il) begin
        idx_hold_q <= idx_cnt_q[31:16];
      end
    end
  end

  // --------------------------------------------------------------------
  // Init/capture value
  // --------------------------------------------------------------------
  // Loaded into the position count by a homing index event
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ic_q <= {`QCR_RST_W16, `QCR_RST_W16};
    end else begin
      if (w_ch) begin
        ic_q[31:16] <= wd;
      end
      if (w_cl) begin
        ic_q[15:0] <= wd;
      end
    end
  end

  // --------------------------------------------------------------------
  // Status flags, enables, mask and interrupt
  // --------------------------------------------------------------------
  reg [7:0] stat_q;
  reg [7:0] stat_d;
  reg [7:0] mask_q;
  reg [7:0] set_v;
  wire [7:0] pend;

  always @* begin
    set_v = `QCR_RST_W8;
    set_v[`QCR_ST_IDX_FLAG] = idx_ev;
    set_v[`QCR_ST_HOME_FLAG] = home_ev;
    set_v[`QCR_ST_HDONE_FLAG] = home_init;
    stat_d = stat_q;
    if (w_st) begin
      stat_d = (stat_q & `QCR_ST_FLAGS & ~i_hwdata[7:0]) |
        (i_hwdata[7:0] & `QCR_ST_ENS);
    end
    stat_d = stat_d | set_v;
  end

  assign pend = stat_q & `QCR_ST_FLAGS & {stat_q[6:0], 1'b0} &
    mask_q;

  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      stat_q <= `QCR_RST_W8;
      mask_q <= `QCR_RST_W8;
      o_irq <= 1'b0;
    end else begin
      stat_q <= stat_d;
      if (w_mk) begin
        mask_q <= i_hwdata[7:0] & `QCR_ST_FLAGS;
      end
      o_irq <= |pend;
    end
  end

  // --------------------------------------------------------------------
  // Read data
  // --------------------------------------------------------------------
  reg [15:0] rd_v;

  always @* begin
    case (addr_q)
      `QCR_OFS_STATUS: rd_v = {8'h00, stat_q};
      `QCR_OFS_POS_HI: rd_v = pos_q[31:16];
      `QCR_OFS_POS_LO: rd_v = pos_q[15:0];
      `QCR_OFS_POS_HOLD: rd_v = pos_hold_q;
      `QCR_OFS_VEL: rd_v = vel_q;
      `QCR_OFS_IDX_HI: rd_v = idx_cnt_q[31:16];
      `QCR_OFS_IDX_LO: rd_v = idx_cnt_q[15:0];
      `QCR_OFS_IDX_HOLD: rd_v = idx_hold_q;
      `QCR_OFS_IC_HI: rd_v = ic_q[31:16];
      `QCR_OFS_IC_LO: rd_v = ic_q[15:0];
      `QCR_OFS_CTRL: rd_v = {9'h000, ctrl_q};
      `QCR_OFS_MASK: rd_v = {8'h00, mask_q};
      default: rd_v = 16'h0000;
    endcase
  end

  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_hrdata <= 32'h0000_0000;
    end else if (act) begin
      o_hrdata <= do_rd ? {16'h0000, rd_v} : 32'h0000_0000;
    end
  end

endmodule // qcr_top

// File: rtl/qcr_defs.vh
/*
 * Constants of the quadrature counter register block: register offsets,
 * field positions, reset values and mode codes.
 * Assumes a 32-bit AHB-Lite bus with one word per register.
 */
`ifndef QCR_DEFS_VH
`define QCR_DEFS_VH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define QCR_OFS_STATUS 6'h00
`define QCR_OFS_POS_HI 6'h04
`define QCR_OFS_POS_LO 6'h08
`define QCR_OFS_POS_HOLD 6'h0C
`define QCR_OFS_VEL 6'h10
`define QCR_OFS_IDX_HI 6'h14
`define QCR_OFS_IDX_LO 6'h18
`define QCR_OFS_IDX_HOLD 6'h1C
`define QCR_OFS_IC_HI 6'h20
`define QCR_OFS_IC_LO 6'h24
`define QCR_OFS_CTRL 6'h28
`define QCR_OFS_MASK 6'h2C

// ----------------------------------------------------------------------
// Status and mask field positions
// ----------------------------------------------------------------------
`define QCR_ST_IDX_EN 0
`define QCR_ST_IDX_FLAG 1
`define QCR_ST_HOME_EN 2
`define QCR_ST_HOME_FLAG 3
`define QCR_ST_HDONE_EN 6
`define QCR_ST_HDONE_FLAG 7
`define QCR_ST_FLAGS 8'h8A
`define QCR_ST_ENS 8'h45

// ----------------------------------------------------------------------
// Control field positions
// ----------------------------------------------------------------------
`define QCR_CT_CCM_LSB 0
`define QCR_CT_PIM_LSB 2
`define QCR_CT_IMV_LSB 5

// ----------------------------------------------------------------------
// Reset values and mode codes
// ----------------------------------------------------------------------
`define QCR_RST_W16 16'h0000
`define QCR_RST_W8 8'h00
`define QCR_RST_CTRL 7'h00
`define QCR_CCM_QUAD 2'h0
`define QCR_CCM_EXT_DIR 2'h1
`define QCR_PIM_HOME_A 3'h3
`define QCR_PIM_HOME_B 3'h4

`endif

// File: tb/qcr_props.sv
/* Port checker of qcr_top: bus timing, read data and interrupt.
   Assumes the bind below and one AHB-Lite master. */
`timescale 1ns/1ps
module qcr_props #(
  parameter ADDR_W = 8
) (
  input wire i_clk,
  input wire i_arst_n,
  input wire i_hsel,
  input wire [ADDR_W-1:0] i_haddr,
  input wire [1:0] i_htrans,
  input wire i_hwrite,
  input wire i_hready,
  input wire [31:0] o_hrdata,
  input wire o_hreadyout,
  input wire o_hresp,
  input wire i_index,
  input wire i_home,
  input wire o_irq
);
  // ------
  // Recent writes and events
  // ------
  wire acc = i_hsel && i_htrans[1] && i_hready;
  wire wr = acc && i_hwrite;
  reg idx_q;
  reg home_q;
  reg [3:0] wr_q;
  reg [3:0] ev_q;
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      idx_q <= 1'b0;
      home_q <= 1'b0;
      wr_q <= 4'h0;
      ev_q <= 4'h0;
    end else begin
      idx_q <= i_index;
      home_q <= i_home;
      wr_q <= {wr_q[2:0], wr};
      ev_q <= {ev_q[2:0], wr || (i_index && !idx_q) || (i_home && !home_q)};
    end
  end
  // ------
  // Properties
  // ------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  property p_okay; !o_hresp; endproperty
  property p_wait; acc |=> !o_hreadyout ##1 o_hreadyout; endproperty
  property p_idle; !acc |=> o_hreadyout; endproperty
  property p_hi_zero; o_hrdata[31:16] == 16'h0000; endproperty
  property p_rd_hold; $changed(o_hrdata) |-> !$past(o_hreadyout); endproperty
  property p_unmapped;
    acc && !i_hwrite && (i_haddr >> 6) != 0 |=> ##1 o_hrdata == 32'h0;
  endproperty
  property p_irq_fall; $fell(o_irq) |-> |wr_q; endproperty
  property p_irq_rise; $rose(o_irq) |-> |ev_q; endproperty
  a_okay: assert property (p_okay) else $error("not OKAY");
  a_wait: assert property (p_wait) else $error("bad wait state");
  a_idle: assert property (p_idle) else $error("ready low when idle");
  a_hi_zero: assert property (p_hi_zero) else $error("upper bits");
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read");
  a_irq_fall: assert property (p_irq_fall) else $error("irq fell");
  a_irq_rise: assert property (p_irq_rise) else $error("irq rose");
  c_irq: cover property ($rose(o_irq));
  c_read: cover property (acc && !i_hwrite);
  c_b2b: cover property (acc ##3 acc);
endmodule // qcr_props
bind qcr_top qcr_props #(.ADDR_W(ADDR_W)) i_props (.i_clk(i_clk),
  .i_arst_n(i_arst_n), .i_hsel(i_hsel), .i_haddr(i_haddr),
  .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hready(i_hready),
  .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
  .i_index(i_index), .i_home(i_home), .o_irq(o_irq));

// File: tb/qcr_enc_model.sv
/* Rotary encoder model: phases A and B, index and home.
   Assumes its tasks are called just after a clock edge. */
`timescale 1ns/1ps
module qcr_enc_model (
  input wire i_clk,
  output logic o_qea = 1'b0,
  output logic o_qeb = 1'b0,
  output logic o_index = 1'b0,
  output logic o_home = 1'b0
);
  logic [1:0] ph_q = 2'h0;
  // One Gray step, then a random dwell
  task automatic step(input bit up);
    ph_q = up ? ph_q + 2'h1 : ph_q - 2'h1;
    @(posedge i_clk);
    o_qea <= ^ph_q;
    o_qeb <= ph_q[1];
    repeat (1 + $urandom % 3) @(posedge i_clk);
  endtask
  // Index or home pulse, two cycles wide
  task automatic pulse(input bit home);
    @(posedge i_clk);
    o_index <= !home;
    o_home <= home;
    repeat (2) @(posedge i_clk);
    o_index <= 1'b0;
    o_home <= 1'b0;
    repeat (3) @(posedge i_clk);
  endtask
endmodule // qcr_enc_model

// File: tb/tb_qcr_top.sv
/* Self-checking bench of the quadrature counter register block.
   Assumes qcr_top, the encoder model and the bound checker. */
`timescale 1ns/1ps
module tb_qcr_top;
  logic clk, arst_n, hsel, hwrite, hready, hresp, irq, rd_ph;
  logic qea, qeb, index, home;
  logic [7:0] haddr;
  logic [2:0] hsize;
  logic [1:0] htrans;
  logic [31:0] hwdata, hrdata, v;
  logic [15:0] h, l, cl;
  logic [31:0] exp_q[$];
  int mismatches, comparisons;
  qcr_top #(.ADDR_W(8)) i_dut (.i_clk(clk), .i_arst_n(arst_n),
    .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
    .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hready),
    .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
    .i_qea(qea), .i_qeb(qeb), .i_index(index), .i_home(home), .o_irq(irq));
  qcr_enc_model i_enc (.i_clk(clk), .o_qea(qea), .o_qeb(qeb),
    .o_index(index), .o_home(home));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] want);
    comparisons++;
    if (seen !== want) begin
      mismatches++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'b1 && n < 20);
    if (hready !== 1'b1) begin
      mismatches++;
      report_and_stop();
    end
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [15:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    hsize <= 3'h2;
    htrans <= 2'h2;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= {16'h0, d};
    wait_rdy();
  endtask
  task rd(input logic [7:0] a, input logic [15:0] e);
    exp_q.push_back({16'h0, e});
    bus(1'b0, a, 16'h0);
  endtask
  task irqis(input logic b);
    repeat (4) @(posedge clk);
    chk({31'h0, irq}, {31'h0, b});
  endtask
  // Read data checked when its data phase ends
  always @(posedge clk) begin
    if (rd_ph && hready) chk(hrdata, exp_q.pop_front());
    if (hready) rd_ph <= hsel && htrans[1] && !hwrite;
  end
  initial begin
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    hsize = 3'h2;
    arst_n = 1'b0;
    mismatches = 0;
    comparisons = 0;
    void'($urandom(32'h6045220E));
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    for (int a = 0; a < 12; a++) rd(8'(4 * a), 16'h0);
    rd(8'h40, 16'h0);
    for (int b = 4; b < 21; b += 16) begin
      h = 16'($urandom);
      l = 16'($urandom);
      bus(1'b1, 8'(b + 8), h);
      bus(1'b1, 8'(b + 4), l);
      bus(1'b1, 8'(b + 8), 16'h0);
      rd(8'(b), h);
      rd(8'(b + 4), l);
      rd(8'(b + 8), h);
      bus(1'b1, 8'(b), l);
      rd(8'(b), l);
    end
    v = {l, l} + 32'h1;
    cl = 16'($urandom);
    bus(1'b1, 8'h10, cl);
    rd(8'h10, cl);
    bus(1'b1, 8'h20, ~cl);
    bus(1'b1, 8'h24, cl);
    rd(8'h20, ~cl);
    rd(8'h24, cl);
    bus(1'b1, 8'h0C, 16'h0);
    bus(1'b1, 8'h08, 16'h0);
    bus(1'b1, 8'h10, 16'h0);
    for (int i = 0; i < 7; i++) i_enc.step(i >= 2);
    rd(8'h08, 16'h3);
    rd(8'h0C, 16'h0);
    rd(8'h10, 16'h3);
    bus(1'b1, 8'h00, 16'h1);
    bus(1'b1, 8'h2C, 16'h8A);
    bus(1'b1, 8'h28, 16'h40);
    i_enc.pulse(1'b0);
    irqis(1'b1);
    rd(8'h00, 16'h3);
    rd(8'h08, 16'h0);
    rd(8'h18, v[15:0]);
    rd(8'h1C, v[31:16]);
    bus(1'b1, 8'h00, 16'h3);
    irqis(1'b0);
    rd(8'h00, 16'h1);
    bus(1'b1, 8'h00, 16'h0);
    bus(1'b1, 8'h28, 16'h0);
    i_enc.pulse(1'b0);
    irqis(1'b0);
    rd(8'h00, 16'h2);
    bus(1'b1, 8'h00, 16'h1);
    irqis(1'b1);
    bus(1'b1, 8'h00, 16'h2);
    i_enc.pulse(1'b1);
    irqis(1'b0);
    bus(1'b1, 8'h00, 16'h4);
    irqis(1'b1);
    rd(8'h00, 16'hC);
    bus(1'b1, 8'h00, 16'h8);
    irqis(1'b0);
    for (int m = 0; m < 8; m++) begin
      bus(1'b1, 8'h28, 16'(m * 4));
      i_enc.pulse(1'b1);
      i_enc.pulse(1'b0);
      rd(8'h00, (m == 3 || m == 4) ? 16'h8A : 16'h0A);
      if (m == 4) rd(8'h08, cl);
      bus(1'b1, 8'h00, 16'h8A);
    end
    bus(1'b1, 8'h28, 16'h1);
    bus(1'b1, 8'h0C, 16'h0);
    bus(1'b1, 8'h08, 16'h0);
    for (int i = 0; i < 4; i++) i_enc.step(1'b1);
    rd(8'h08, 16'hFFFF);
    rd(8'h0C, 16'hFFFF);
    repeat (2) @(posedge clk);
    report_and_stop();
  end
endmodule // tb_qcr_top
